/* File: i2c_addr_capture.v */
// Shifts in the first byte after a start condition and pulses once at the
// rising edge of its eighth clock, with the complete byte alongside.
// Assumes single-cycle scl_rise and start_det strobes from the synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_consts.vh"

module i2c_addr_capture (
	input  wire       sys_clk,
	input  wire       srst,
	input  wire       clk_en,
	input  wire       scl_rise,
	input  wire       sda_level,
	input  wire       start_det,
	input  wire       stop_det,
	output reg        eighth_clk,
	output reg  [7:0] addr_byte
);

	reg  [3:0] bit_count;
	reg        capturing;

	// Only the address byte is of interest, so capture stops after bit eight
	always @(posedge sys_clk) begin
		if (srst) begin
			bit_count  <= 4'h0;
			capturing  <= 1'b0;
			eighth_clk <= 1'b0;
			addr_byte  <= 8'h00;
		end else if (clk_en) begin
			eighth_clk <= 1'b0;
			if (start_det) begin
				bit_count <= 4'h0;
				capturing <= 1'b1;
			end else if (stop_det) begin
				capturing <= 1'b0;
			end else if (capturing && scl_rise) begin
				addr_byte <= {addr_byte[6:0], sda_level};
				bit_count <= bit_count + 4'h1;
				if (bit_count == (`ADDR_BITS - 4'h1)) begin
					eighth_clk <= 1'b1;
					capturing  <= 1'b0;
				end
			end
		end
	end

endmodule // i2c_addr_capture

`default_nettype wire

/* File: i2c_far_master.sv */
// Far-side bus master: start, one address byte MSB first, stop.
// Assumes pull-ups, so both lines rest high and the clock stands between frames.
`timescale 1ns/1ps
`default_nettype none
module i2c_far_master (
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Clock left high after the eighth bit so the flags can be read
	task automatic frame(input logic [7:0] b);
		#7; // Keeps every line change off the system clock edge
		sda = 1'b0;
		#400;
		for (int i = 7; i >= 0; i--) begin
			scl = 1'b0;
			#200 sda = b[i];
			#200 scl = 1'b1;
			#400;
		end
	endtask
	// Data rises while the clock is high
	task automatic stop();
		#7; // Same phase offset as a frame
		scl = 1'b0;
		#200 sda = 1'b0;
		#200 scl = 1'b1;
		#400 sda = 1'b1;
		#400;
	endtask
endmodule // i2c_far_master
`default_nettype wire

/* File: i2c_pin_sync.v */
// Two-stage synchroniser for the serial clock and data lines, with
// start, stop and clock rising edge detection on the synchronised levels.
// Assumes the lines are asynchronous to sys_clk and much slower than it.
`timescale 1ns/1ps
`default_nettype none

module i2c_pin_sync (
	input  wire       sys_clk,
	input  wire       srst,
	input  wire       clk_en,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        scl_level,
	output reg        sda_level,
	output reg        scl_rise,
	output reg        start_det,
	output reg        stop_det
);

	reg  [1:0] scl_meta;
	reg  [1:0] sda_meta;

	// First stage feeds only the second; idle bus reads high after reset
	always @(posedge sys_clk) begin
		if (srst) begin
			scl_meta <= 2'h3;
			sda_meta <= 2'h3;
		end else if (clk_en) begin
			scl_meta <= {scl_meta[0], scl_in};
			sda_meta <= {sda_meta[0], sda_in};
		end
	end

	// Edge detection looks only at the second stage and its delayed copy
	always @(posedge sys_clk) begin
		if (srst) begin
			scl_level <= 1'b1;
			sda_level <= 1'b1;
			scl_rise  <= 1'b0;
			start_det <= 1'b0;
			stop_det  <= 1'b0;
		end else if (clk_en) begin
			scl_level <= scl_meta[1];
			sda_level <= sda_meta[1];
			scl_rise  <= scl_meta[1] & ~scl_level;
			start_det <= scl_meta[1] & scl_level & sda_level & ~sda_meta[1];
			stop_det  <= scl_meta[1] & scl_level & ~sda_level & sda_meta[1];
		end
	end

endmodule // i2c_pin_sync

`default_nettype wire

/* File: i2c_status_consts.vh */
// Constants for the I2C channel status flag block: register address,
// field positions inside the status byte and the control byte, reset value.
// Assumes inclusion by bare name from the design files of this block.
`ifndef I2C_STATUS_CONSTS_VH
`define I2C_STATUS_CONSTS_VH

// Byte address of the status register on the internal memory bus
`define BUS_STATUS_ADDR     32'hfffff342
// Reset value of the status register
`define BUS_STATUS_RESET    8'h00

// Status byte field positions
`define MASTER_ACTIVE_BIT   7
`define ARB_LOST_BIT        6
`define EXT_CODE_BIT        5
`define ADDR_MATCH_BIT      4
`define TX_RX_STATE_BIT     3
`define ACK_SEEN_BIT        2
`define START_SEEN_BIT      1
`define STOP_SEEN_BIT       0

// Control byte field positions
`define CHANNEL_ENABLE_BIT  7
`define RELEASE_TRIGGER_BIT 6

// Upper nibble patterns of an extension code address byte
`define EXT_CODE_LOW        4'h0
`define EXT_CODE_HIGH       4'hf

// Clock edges counted for one address byte
`define ADDR_BITS           4'h8

`endif

/* File: i2c_status_flags.v */
// Status flag logic for one I2C channel: master active, arbitration lost,
// extension code and address match, gathered with four flags kept by
// other logic into the read-only status byte on the internal memory bus.
// Assumes control byte, slave address and transmitter signals come from
// sys_clk logic; the bus lines are asynchronous and get synchronised here.
//
// Summary of operation
// (RQ1) The status byte ignores CPU writes and reset clears every bit to zero.
// (RQ2) The status byte answers whole byte reads and single-bit instruction reads alike.
// (RQ3) Bits 7 to 0 are master active, arb lost, ext code, addr match, tx/rx, ack, start, stop.
// (RQ4) Master active sets when this channel generates a start condition.
// (RQ5) Master active clears on stop, arbitration loss, release trigger, enable fall or reset.
// (RQ6) Arb lost sets on losing arbitration and master active clears in the same cycle.
// (RQ7) Arb lost clears on a status read, on enable fall or on reset.
// (RQ8) Ext code sets at the eighth clock rise when the address nibble is 0000 or 1111.
// (RQ9) Ext code clears on start, stop, release trigger or enable fall.
// (RQ10) Addr match sets at the eighth clock rise when the address equals the slave address.
// (RQ11) Addr match clears on start, stop, release trigger, enable fall or reset.
// (RQ12) The release trigger is bit 6 of the channel control byte.
// (RQ13) The channel enable is bit 7 of the channel control byte.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_consts.vh"

module i2c_status_flags (
	input  wire        sys_clk,
	input  wire        srst,
	input  wire        clk_en,
	input  wire        scl_in,
	input  wire        sda_in,
	input  wire [7:0]  channel_control_reg,
	input  wire [7:0]  local_slave_addr,
	input  wire        start_gen,
	input  wire        tx_drive_high,
	input  wire        tx_rx_state_flag,
	input  wire        ack_seen_flag,
	input  wire        start_seen_flag,
	input  wire        stop_seen_flag,
	input  wire [31:0] cpu_addr,
	input  wire        cpu_rd,
	input  wire        cpu_wr,
	input  wire [7:0]  cpu_wdata,
	output reg  [7:0]  cpu_rdata,
	output reg         cpu_rd_valid,
	output reg  [7:0]  bus_status_reg
);

	wire       scl_level;
	wire       sda_level;
	wire       scl_rise;
	wire       start_det;
	wire       stop_det;
	wire       eighth_clk;
	wire [7:0] addr_byte;

	reg        master_active_flag;
	reg        arb_lost_flag;
	reg        ext_code_flag;
	reg        addr_match_flag;
	reg        enable_prev;

	wire       channel_enable_bit;
	wire       bus_release_trigger;
	wire       enable_fall;
	wire       status_hit;
	wire       status_read;
	wire       arb_loss;
	wire       ext_code_seen;
	wire       addr_equal;
	wire       common_clear;
	wire [7:0] status_word;
	wire       write_ignored;

	// Synchronise the bus lines and find start, stop and clock rises
	i2c_pin_sync u_pin_sync (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.clk_en    (clk_en),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.scl_level (scl_level),
		.sda_level (sda_level),
		.scl_rise  (scl_rise),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// Collect the address byte and mark its eighth clock
	i2c_addr_capture u_addr_capture (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.clk_en     (clk_en),
		.scl_rise   (scl_rise),
		.sda_level  (sda_level),
		.start_det  (start_det),
		.stop_det   (stop_det),
		.eighth_clk (eighth_clk),
		.addr_byte  (addr_byte)
	);

	// Control byte fields that steer the flags
	assign channel_enable_bit  = channel_control_reg[`CHANNEL_ENABLE_BIT];  // RQ13
	assign bus_release_trigger = channel_control_reg[`RELEASE_TRIGGER_BIT]; // RQ12

	// Remember the enable so that only a 1 to 0 change clears flags
	always @(posedge sys_clk) begin
		if (srst) begin
			enable_prev <= 1'b0;
		end else if (clk_en) begin
			enable_prev <= channel_enable_bit;
		end
	end

	assign enable_fall = enable_prev & ~channel_enable_bit; // RQ13

	// Address decode; a bit instruction still fetches the whole byte
	assign status_hit  = (cpu_addr == `BUS_STATUS_ADDR);
	assign status_read = status_hit & cpu_rd; // RQ2

	// Writes reach this decode but change nothing
	assign write_ignored = status_hit & cpu_wr & (|cpu_wdata | 1'b1); // RQ1

	// Loss: we release the data line for a one but another device pulls it low
	assign arb_loss = master_active_flag & tx_drive_high & scl_rise & ~sda_level; // RQ6

	// Address checks made at the eighth clock rise, byte includes bit eight
	assign ext_code_seen = (addr_byte[7:4] == `EXT_CODE_LOW) |
		(addr_byte[7:4] == `EXT_CODE_HIGH); // RQ8
	assign addr_equal = (addr_byte[7:1] == local_slave_addr[7:1]); // RQ10

	// Conditions shared by the ext code and addr match flags
	assign common_clear = start_det | stop_det | bus_release_trigger | enable_fall;

	// Master active: set by our own start, cleared by stop, loss, release, enable fall
	always @(posedge sys_clk) begin
		if (srst) begin
			master_active_flag <= 1'b0; // RQ5
		end else if (clk_en) begin
			if (stop_det | arb_loss | bus_release_trigger | enable_fall) begin
				master_active_flag <= 1'b0; // RQ5
			end else if (start_gen) begin
				master_active_flag <= 1'b1; // RQ4
			end
		end
	end

	// Arbitration lost: the set wins over the read clear so no loss goes unseen
	always @(posedge sys_clk) begin
		if (srst) begin
			arb_lost_flag <= 1'b0; // RQ7
		end else if (clk_en) begin
			if (arb_loss) begin
				arb_lost_flag <= 1'b1; // RQ6
			end else if (status_read | enable_fall) begin
				arb_lost_flag <= 1'b0; // RQ7
			end
		end
	end

	// Extension code flag; the eighth clock never coincides with start or stop
	always @(posedge sys_clk) begin
		if (srst) begin
			ext_code_flag <= 1'b0;
		end else if (clk_en) begin
			if (eighth_clk & ext_code_seen) begin
				ext_code_flag <= 1'b1; // RQ8
			end else if (common_clear) begin
				ext_code_flag <= 1'b0; // RQ9
			end
		end
	end

	// Address match flag
	always @(posedge sys_clk) begin
		if (srst) begin
			addr_match_flag <= 1'b0; // RQ11
		end else if (clk_en) begin
			if (eighth_clk & addr_equal) begin
				addr_match_flag <= 1'b1; // RQ10
			end else if (common_clear) begin
				addr_match_flag <= 1'b0; // RQ11
			end
		end
	end

	// Status byte layout, upper nibble kept here, lower nibble from other logic
	assign status_word = {master_active_flag, arb_lost_flag, ext_code_flag,
		addr_match_flag, tx_rx_state_flag, ack_seen_flag,
		start_seen_flag, stop_seen_flag}; // RQ3

	// Registered view of the status byte and the CPU read answer
	always @(posedge sys_clk) begin
		if (srst) begin
			bus_status_reg <= `BUS_STATUS_RESET; // RQ1
			cpu_rdata      <= 8'h00;
			cpu_rd_valid   <= 1'b0;
		end else if (clk_en) begin
			bus_status_reg <= status_word;
			cpu_rd_valid   <= status_read;
			if (status_read) begin
				// Value returned is the one before the read clears arb lost
				cpu_rdata <= status_word; // RQ2
			end else begin
				cpu_rdata <= 8'h00;
			end
		end
	end

endmodule // i2c_status_flags

`default_nettype wire

/* File: i2c_status_flags_props.sv */
// Checker for the status flag block, bound to its top module.
// Attempts other than a_reset_zero are dropped when they meet a low clk_en, since the block is frozen then.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_consts.vh"
module i2c_status_flags_props (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        clk_en,
	input wire logic [7:0]  channel_control_reg,
	input wire logic        start_gen,
	input wire logic [31:0] cpu_addr,
	input wire logic        cpu_rd,
	input wire logic [7:0]  cpu_rdata,
	input wire logic        cpu_rd_valid,
	input wire logic [7:0]  bus_status_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst || !clk_en);
	// A read taken at the status address
	wire hit = cpu_rd && cpu_addr == `BUS_STATUS_ADDR;
	// Reads answer one cycle later with the same byte as the live copy
	a_rd_answer: assert property (hit |=> cpu_rd_valid && cpu_rdata == bus_status_reg)
		else $error("status read not answered");
	a_rd_quiet: assert property (!hit |=> !cpu_rd_valid)
		else $error("answer without a status read");
	// No start_gen nearby, so no fresh loss can race the read clear
	a_arb_rd_clear: assert property (hit && !start_gen && !$past(start_gen)
		&& !bus_status_reg[7] |-> ##2 !bus_status_reg[6])
		else $error("arb lost survived a read");
	a_en_fall_clear: assert property ($fell(channel_control_reg[7])
		|-> ##[2:3] bus_status_reg[7:4] == 4'h0)
		else $error("enable fall left flags set");
	a_release_clear: assert property (channel_control_reg[6]
		|-> ##[2:3] !bus_status_reg[7] && bus_status_reg[5:4] == 2'h0)
		else $error("release left flags set");
	a_master_set: assert property (start_gen && channel_control_reg[7:6] == 2'h2
		|-> ##2 bus_status_reg[7])
		else $error("start gen did not set master");
	a_arb_pair: assert property ($rose(bus_status_reg[6]) |-> $fell(bus_status_reg[7]))
		else $error("arb lost without master clear");
	a_reset_zero: assert property (disable iff (1'b0) srst |=> bus_status_reg == 8'h00)
		else $error("reset left status set");
	cover property (hit && bus_status_reg[6]);
	cover property ($rose(bus_status_reg[5]));
	cover property ($rose(bus_status_reg[4]));
endmodule // i2c_status_flags_props
bind i2c_status_flags i2c_status_flags_props props_u (.sys_clk(sys_clk), .srst(srst),
	.channel_control_reg(channel_control_reg), .start_gen(start_gen), .cpu_addr(cpu_addr),
	.cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rd_valid(cpu_rd_valid),
	.bus_status_reg(bus_status_reg), .clk_en(clk_en));
`default_nettype wire

/* File: i2c_status_flags_tb.sv */
// Testbench for the status flag block with a far-side bus master.
// Assumes design, checker and bus model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_consts.vh"
module i2c_status_flags_tb;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        clk_en = 1'b1;
	logic [7:0]  ctl = 8'h80;
	logic [7:0]  sla = 8'ha4;
	logic        start_gen = 1'b0;
	logic        tx_hi = 1'b0;
	logic [3:0]  low = 4'h0;
	logic [31:0] addr = `BUS_STATUS_ADDR;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [7:0]  rdata, stat;
	logic        valid, scl, sda;
	int          err_total = 0;
	int          tests_run = 0;
	logic [7:0]  codes [4] = '{8'h02, 8'hf1, 8'ha5, 8'h5e};
	logic [7:0]  flags [4] = '{8'h20, 8'h20, 8'h10, 8'h00};
	always #50 sys_clk = ~sys_clk;
	i2c_far_master far (.scl(scl), .sda(sda));
	i2c_status_flags DUT (
		.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
		.channel_control_reg(ctl), .local_slave_addr(sla), .start_gen(start_gen),
		.tx_drive_high(tx_hi), .tx_rx_state_flag(low[3]), .ack_seen_flag(low[2]),
		.start_seen_flag(low[1]), .stop_seen_flag(low[0]), .cpu_addr(addr), .cpu_rd(rd),
		.cpu_wr(wr), .cpu_wdata(8'hff), .cpu_rdata(rdata), .cpu_rd_valid(valid),
		.bus_status_reg(stat)
	);
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// The answer stands one cycle only, so it is looked at right after that edge
	task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		chk("valid", {7'h0, a == `BUS_STATUS_ADDR}, {7'h0, valid});
		if (a == `BUS_STATUS_ADDR) chk("status", exp, rdata);
	endtask
	task automatic go_master();
		@(posedge sys_clk);
		start_gen <= 1'b1;
		@(posedge sys_clk);
		start_gen <= 1'b0;
	endtask
	// Clear by stop, release trigger or enable fall, check, then idle the bus
	task automatic clr(input int k);
		if (k == 0) far.stop();
		else begin
			@(posedge sys_clk);
			ctl <= (k == 1) ? 8'hc0 : 8'h00;
			@(posedge sys_clk);
			ctl <= 8'h80;
		end
		cyc(6);
		rd_chk(`BUS_STATUS_ADDR, 8'h00);
		if (k != 0) far.stop();
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog cuts a hang short
	initial begin
		cyc(20000);
		err_total++;
		finish_test();
	end
	initial begin
		cyc(5);
		srst <= 1'b0;
		rd_chk(`BUS_STATUS_ADDR, 8'h00);
		@(posedge sys_clk);
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd_chk(`BUS_STATUS_ADDR, 8'h00);
		rd_chk(32'hfffff343, 8'h00);
		@(posedge sys_clk);
		low <= 4'ha;
		rd_chk(`BUS_STATUS_ADDR, 8'h0a);
		@(posedge sys_clk);
		low <= 4'h5;
		rd_chk(`BUS_STATUS_ADDR, 8'h05);
		@(posedge sys_clk);
		low <= 4'h0;
		// Address byte cases: both extension nibbles, a match, neither
		for (int i = 0; i < 4; i++) begin
			far.frame(codes[i]);
			cyc(8);
			rd_chk(`BUS_STATUS_ADDR, flags[i]);
			clr(i % 3);
		end
		for (int k = 0; k < 3; k++) begin
			go_master();
			cyc(2);
			rd_chk(`BUS_STATUS_ADDR, 8'h80);
			clr(k);
		end
		// We release data for a 1 while the far side pulls it low: loss
		@(posedge sys_clk);
		tx_hi <= 1'b1;
		go_master();
		far.frame(8'h00);
		cyc(8);
		rd_chk(`BUS_STATUS_ADDR, 8'h60);
		rd_chk(`BUS_STATUS_ADDR, 8'h20);
		clr(0);
		// Master, arb lost and ext code all set, then a frozen clock, then reset
		go_master();
		far.frame(8'h01);
		go_master();
		cyc(6);
		#1;
		chk("live", 8'he0, stat);
		// Release and enable fall while frozen must leave the flags alone
		@(posedge sys_clk);
		clk_en <= 1'b0;
		ctl <= 8'h40;
		cyc(3);
		ctl <= 8'h80;
		@(posedge sys_clk);
		clk_en <= 1'b1;
		cyc(3);
		#1;
		chk("frozen", 8'he0, stat);
		@(posedge sys_clk);
		srst <= 1'b1;
		cyc(2);
		srst <= 1'b0;
		cyc(2);
		#1;
		chk("reset", 8'h00, stat);
		rd_chk(`BUS_STATUS_ADDR, 8'h00);
		finish_test();
	end
endmodule // i2c_status_flags_tb
`default_nettype wire
